// >>> pkg/dtm_pkg.sv
/*
  Constants, register map and carrier types for the display timing and
  mode strap block.
  Assumes a 200 MHz system clock and a display clock near 8 MHz.
*/
package dtm_pkg;

  // Clock rates and derived counts
  localparam int SYS_CLK_PERIOD_NS  = 5;
  localparam int DISP_CLK_PERIOD_NS = 125;
  localparam int OSC_HALF_CYC       = DISP_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  localparam int OSC_W              = 8;

  // Display frame geometry
  localparam int LINES_PER_FRAME    = 65;
  localparam int LINE_W             = 8;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;

  // Control register fields and reset value
  localparam int CTRL_DISPLAY_ON_BIT = 0;
  localparam int CTRL_STATIC_ON_BIT  = 1;
  localparam logic [1:0] CTRL_RESET  = 2'h0;

  // Status register fields
  localparam int STAT_PARALLEL_BIT = 0;
  localparam int STAT_CLK_INT_BIT  = 1;
  localparam int STAT_MASTER_BIT   = 2;
  localparam int STAT_INT_RES_BIT  = 3;
  localparam int STAT_HI_PWR_BIT   = 4;
  localparam int STAT_CFG_RUN_BIT  = 5;
  localparam int STAT_FRAME_BIT    = 6;
  localparam int STAT_BLANK_N_BIT  = 7;
  localparam int STAT_READBACK_BIT = 8;
  localparam int STAT_LINE_LSB     = 16;

  // Captured strap levels
  typedef struct packed {
    logic parallel_if;
    logic clk_src_int;
    logic master;
    logic regulator_resistor_select;
    logic hpm_n;
  } dtm_straps_t;

  // Software control bits
  typedef struct packed {
    logic static_on;
    logic display_on;
  } dtm_ctrl_t;

  // Synchronised link pin levels
  typedef struct packed {
    logic blank_n;
    logic frame;
    logic clk;
  } dtm_link_t;

  // Strap capture sequence
  typedef enum logic [1:0] {
    CFG_SETTLE0 = 2'b00,
    CFG_SETTLE1 = 2'b01,
    CFG_SETTLE2 = 2'b11,
    CFG_RUN     = 2'b10
  } dtm_cfg_state_t;

endpackage

// >>> tb/dtm_partner_chip.sv
/*
  Behavioural partner chip running as display timing master.
  Assumes the bench resolves the shared pins from the output enables.
*/
module dtm_partner_chip #(
  parameter int LINES = 65
) (
  // Control from bench
  input  wire logic i_enable,
  input  wire logic i_blank_n,
  // Link pins driven as master
  output logic      o_clk,
  output logic      o_frame,
  output logic      o_blank_n,
  output logic      o_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  int line_cnt = 0;

  initial o_clk = 1'b0;
  initial o_frame = 1'b0;

  // Shared display clock, stands still while disabled; edges kept off system clock edges
  initial
  begin
    #1.25;
    forever #62.5 o_clk = i_enable ? !o_clk : 1'b0;
  end

  // Frame level flips once per LINES rising clock edges
  always @(posedge o_clk)
  begin
    line_cnt = line_cnt + 1;
    if (line_cnt == LINES)
    begin
      line_cnt = 0;
      o_frame = !o_frame;
    end
  end

  // Blanking level and drive enable
  assign o_blank_n = i_blank_n;
  assign o_oe      = i_enable;
endmodule

// >>> tb/tb_top.sv
/*
  Self-checking bench for the display timing and mode strap block.
  Assumes straps change only inside reset and one partner chip on the link.
*/
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %0h seen %0h", n, e, g); failures++; end end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int NL = 9;
  localparam int OH = 12;

  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic [3:0]           avs_address = 4'h0;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [31:0]          avs_writedata = 32'h0;
  logic [3:0]           avs_byteenable = 4'h0;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  dtm_pkg::dtm_straps_t st = '0;
  logic                 clk_pin, dut_clk, dut_clk_oe;
  logic                 frame_pin, dut_frame, dut_frame_oe;
  logic                 blank_pin, dut_blank, dut_blank_oe;
  logic                 static_out, osc_en, int_res, hi_pwr, readback, tick, frame_lvl, blank_act;
  logic                 p_en = 1'b0;
  logic                 p_blank = 1'b0;
  logic                 p_clk, p_frame, p_blank_out, p_oe;
  int                   cyc;
  int                   hi;
  logic [31:0]          q;
  int                   failures = 0;
  int                   checks_done = 0;
  int                   t;

  // System clock
  always #2.5 sys_clk = !sys_clk;

  // Undriven pins rest at pull levels: clock and frame low, blanking high
  assign clk_pin   = dut_clk_oe ? dut_clk : (p_oe ? p_clk : 1'b0);
  assign frame_pin = dut_frame_oe ? dut_frame : (p_oe ? p_frame : 1'b0);
  assign blank_pin = dut_blank_oe ? dut_blank : (p_oe ? p_blank_out : 1'b1);

  dtm_partner_chip #(.LINES(NL)) partner (.i_enable(p_en), .i_blank_n(p_blank),
    .o_clk(p_clk), .o_frame(p_frame), .o_blank_n(p_blank_out), .o_oe(p_oe));

  dtm_display_timing #(.OSC_HALF(OH), .LINES(NL)) dut (
    .i_sys_clk(sys_clk), .i_reset(rst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .i_interface_select(st.parallel_if), .i_clock_source_select(st.clk_src_int),
    .i_master_slave(st.master), .i_regulator_resistor_select(st.regulator_resistor_select),
    .i_high_power_mode_n(st.hpm_n),
    .i_display_clock_pin(clk_pin), .o_display_clock_pin(dut_clk),
    .o_display_clock_pin_oe(dut_clk_oe),
    .i_ac_drive_frame(frame_pin), .o_ac_drive_frame(dut_frame),
    .o_ac_drive_frame_oe(dut_frame_oe),
    .i_display_blank_n(blank_pin), .o_display_blank_n(dut_blank),
    .o_display_blank_n_oe(dut_blank_oe), .o_static_drive_out(static_out),
    .o_osc_enable(osc_en), .o_use_internal_resistors(int_res),
    .o_high_power_mode(hi_pwr), .o_readback_enable(readback), .o_display_tick(tick),
    .o_frame_level(frame_lvl), .o_blank_active(blank_act));

  // Verdict and end of run
  task close_out();
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Reset with new strap levels
  task cfg(input logic [4:0] s);
    @(posedge sys_clk);
    rst <= 1'b1;
    st <= dtm_pkg::dtm_straps_t'(s);
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      close_out();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Count ticks until the frame output flips
  task frame_gap();
    int  n;
    logic f;
    f = frame_pin;
    t = 0;
    hi = 0;
    n = 0;
    while (frame_pin === f && n < 3000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      t += (tick === 1'b1);
      hi += (clk_pin === 1'b1);
    end
    cyc = n;
    if (frame_pin === f)
    begin
      failures++;
      close_out();
    end
  endtask

  // Main sequence
  initial
  begin
    // Every strap combination: decoded modes and status
    for (int i = 0; i < 32; i++)
    begin
      cfg(i[4:0]);
      `CHK("modes", {st.clk_src_int, st.master & st.clk_src_int, st.master, st.master,
        st.master & st.regulator_resistor_select, st.master & !st.hpm_n, st.parallel_if},
        {osc_en, dut_clk_oe, dut_frame_oe, dut_blank_oe, int_res, hi_pwr, readback})
      bus(1'b0, 4'h4, 32'h0, 4'hF);
      `CHK("status", {1'b1, st.master & !st.hpm_n, st.master & st.regulator_resistor_select, st.master,
        st.clk_src_int, st.parallel_if}, q[5:0])
      `CHK("status_rb", st.parallel_if, q[8])
    end
    // Master with own oscillator
    cfg(5'b11101);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    `CHK("ctrl_reset", 32'h0, q)
    bus(1'b1, 4'h0, 32'h3, 4'h0);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    `CHK("ctrl_no_lane", 32'h0, q)
    bus(1'b1, 4'h4, 32'hFFFF, 4'hF);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK("status_ro", 6'h27, q[5:0])
    bus(1'b0, 4'h8, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, q)
    bus(1'b1, 4'h0, 32'h3, 4'hF);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("blank_out", 2'b10, {blank_pin, blank_act})
    frame_gap();
    frame_gap();
    `CHK("frame_ticks", NL, t)
    `CHK("frame_len", NL * 2 * OH, cyc)
    `CHK("clk_pin_high", NL * OH, hi)
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("static_on", dut_frame, static_out)
    bus(1'b1, 4'h0, 32'h0, 4'hF);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("static_off", 3'b001, {static_out, blank_pin, blank_act})
    // Slave on an external clock from the partner
    p_en <= 1'b1;
    cfg(5'b10010);
    bus(1'b1, 4'h0, 32'h3, 4'hF);
    t = 0;
    repeat (250)
    begin
      @(posedge sys_clk);
      #1;
      t += (tick === 1'b1);
    end
    `CHK("ext_ticks", 1'b1, (t >= 9 && t <= 11))
    `CHK("slave_oe", 4'h0, {dut_clk_oe, dut_frame_oe, dut_blank_oe, static_out})
    for (int k = 0; k < 2; k++)
    begin
      frame_gap();
      repeat (6) @(posedge sys_clk);
      #1;
      `CHK("slave_frame", p_frame, frame_lvl)
      bus(1'b0, 4'h4, 32'h0, 4'hF);
      `CHK("slave_line", {p_frame, 8'h00}, {q[6], q[23:16]})
    end
    p_blank <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK("slave_blank", 1'b0, blank_act)
    p_blank <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK("slave_blank", 1'b1, blank_act)
    close_out();
  end
endmodule

// >>> verilog/dtm_display_timing.sv
/*
  Strap decode and master/slave display timing for a dot-matrix display
  driver, with an Avalon-MM register slave.
  Assumes straps are static while out of reset and that link pins are
  resolved outside from the output enables.
*/
// Notes on behaviour
// - Clock source strap high runs internal oscillator; low uses external clock.
// - Master generates display timing; slave takes it in and follows it.
// - Display clock pins of paired chips are tied, sharing one clock.
// - Frame signal is output in master, input in slave; pins joined.
// - Blanking pin is output in master, input in slave; pins joined.
// - Static drive output active only with static indicator on in master.
// - Master picks internal or external regulator resistors; slave ignores strap.
// - Master picks normal or high power mode; slave ignores strap.
// - Serial interface selection gives write-only access, no readback path.
module dtm_display_timing #(
  parameter int OSC_HALF = dtm_pkg::OSC_HALF_CYC,
  parameter int LINES    = dtm_pkg::LINES_PER_FRAME
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Configuration straps
  input  wire logic        i_interface_select,
  input  wire logic        i_clock_source_select,
  input  wire logic        i_master_slave,
  input  wire logic        i_regulator_resistor_select,
  input  wire logic        i_high_power_mode_n,
  // Display clock pin
  input  wire logic        i_display_clock_pin,
  output logic             o_display_clock_pin,
  output logic             o_display_clock_pin_oe,
  // Frame pin
  input  wire logic        i_ac_drive_frame,
  output logic             o_ac_drive_frame,
  output logic             o_ac_drive_frame_oe,
  // Blanking pin
  input  wire logic        i_display_blank_n,
  output logic             o_display_blank_n,
  output logic             o_display_blank_n_oe,
  // Static indicator drive
  output logic             o_static_drive_out,
  // Decoded mode and display timing to display core and analog
  output logic             o_osc_enable,
  output logic             o_use_internal_resistors,
  output logic             o_high_power_mode,
  output logic             o_readback_enable,
  output logic             o_display_tick,
  output logic             o_frame_level,
  output logic             o_blank_active
);

  localparam int RUN_BOUND_LO = 1;
  localparam int RUN_BOUND_HI = 2 * OSC_HALF + 2;

  // Address match used by read and write paths
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offs);
    reg_hit = (addr == offs);
  endfunction

  dtm_pkg::dtm_straps_t    strap_sync;
  dtm_pkg::dtm_link_t      link_sync;
  dtm_pkg::dtm_straps_t    strap_q, strap_d;
  dtm_pkg::dtm_cfg_state_t cfg_q, cfg_d;
  dtm_pkg::dtm_ctrl_t      ctrl_q, ctrl_d;
  logic                    ack_q, ack_d;
  logic [31:0]             rdata_q, rdata_d;
  logic [dtm_pkg::OSC_W-1:0]  osc_cnt_q, osc_cnt_d;
  logic                    osc_lvl_q, osc_lvl_d;
  logic                    clk_prev_q, frm_prev_q;
  logic [dtm_pkg::LINE_W-1:0] line_q, line_d;
  logic                    frame_q, frame_d;
  logic                    blank_q, blank_d;
  logic                    static_q, static_d;
  logic                    tick_q, tick_d;
  logic                    run, master, ext_rise, osc_rise, frm_edge, tick;
  logic                    frame_lvl, blank_lvl;

  // Straps and link pins cross into the system clock
  dtm_sync2 #(
    .WIDTH (8)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   ({i_interface_select, i_clock_source_select, i_master_slave,
                 i_regulator_resistor_select, i_high_power_mode_n,
                 i_display_blank_n, i_ac_drive_frame, i_display_clock_pin}),
    .o_sync    ({strap_sync, link_sync})
  );

  // Strap capture after reset release, once the synchroniser is filled
  always_comb
  begin
    cfg_d   = cfg_q;
    strap_d = strap_q;
    unique case (cfg_q)
      dtm_pkg::CFG_SETTLE0: cfg_d = dtm_pkg::CFG_SETTLE1;
      dtm_pkg::CFG_SETTLE1: cfg_d = dtm_pkg::CFG_SETTLE2;
      dtm_pkg::CFG_SETTLE2:
      begin
        cfg_d   = dtm_pkg::CFG_RUN;
        strap_d = strap_sync;
      end
      dtm_pkg::CFG_RUN:     cfg_d = dtm_pkg::CFG_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cfg_q   <= dtm_pkg::CFG_SETTLE0;
      strap_q <= '0;
    end
    else
    begin
      cfg_q   <= cfg_d;
      strap_q <= strap_d;
    end
  end

  assign run    = (cfg_q == dtm_pkg::CFG_RUN);
  assign master = run && strap_q.master;

  // Mode decode to display core and analog section
  assign o_osc_enable             = run && strap_q.clk_src_int;
  assign o_use_internal_resistors = master && strap_q.regulator_resistor_select;
  assign o_high_power_mode        = master && !strap_q.hpm_n;
  assign o_readback_enable        = run && strap_q.parallel_if;

  // Avalon slave: one wait state, write lands when waitrequest is low
  always_comb
  begin
    ack_d   = (i_avs_read || i_avs_write) && !ack_q;
    rdata_d = rdata_q;
    ctrl_d  = ctrl_q;
    if (i_avs_read && !ack_q)
    begin
      rdata_d = 32'h0000_0000;
      if (reg_hit(i_avs_address, dtm_pkg::REG_CTRL))
      begin
        rdata_d[dtm_pkg::CTRL_DISPLAY_ON_BIT] = ctrl_q.display_on;
        rdata_d[dtm_pkg::CTRL_STATIC_ON_BIT]  = ctrl_q.static_on;
      end
      else if (reg_hit(i_avs_address, dtm_pkg::REG_STATUS))
      begin
        rdata_d[dtm_pkg::STAT_PARALLEL_BIT] = strap_q.parallel_if;
        rdata_d[dtm_pkg::STAT_CLK_INT_BIT]  = strap_q.clk_src_int;
        rdata_d[dtm_pkg::STAT_MASTER_BIT]   = strap_q.master;
        rdata_d[dtm_pkg::STAT_INT_RES_BIT]  = o_use_internal_resistors;
        rdata_d[dtm_pkg::STAT_HI_PWR_BIT]   = o_high_power_mode;
        rdata_d[dtm_pkg::STAT_CFG_RUN_BIT]  = run;
        rdata_d[dtm_pkg::STAT_FRAME_BIT]    = frame_lvl;
        rdata_d[dtm_pkg::STAT_BLANK_N_BIT]  = blank_lvl;
        rdata_d[dtm_pkg::STAT_READBACK_BIT] = o_readback_enable;
        rdata_d[dtm_pkg::STAT_LINE_LSB +: dtm_pkg::LINE_W] = line_q;
      end
    end
    if (i_avs_write && ack_q && i_avs_byteenable[0] &&
        reg_hit(i_avs_address, dtm_pkg::REG_CTRL))
    begin
      ctrl_d.display_on = i_avs_writedata[dtm_pkg::CTRL_DISPLAY_ON_BIT];
      ctrl_d.static_on  = i_avs_writedata[dtm_pkg::CTRL_STATIC_ON_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q  <= dtm_pkg::CTRL_RESET;
    end
    else
    begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_readdata    = rdata_q;

  // Internal display oscillator, frozen while disabled
  always_comb
  begin
    osc_cnt_d = osc_cnt_q;
    osc_lvl_d = osc_lvl_q;
    if (o_osc_enable)
    begin
      osc_cnt_d = osc_cnt_q + 1'b1;
      if (osc_cnt_q == dtm_pkg::OSC_W'(OSC_HALF - 1))
      begin
        osc_cnt_d = '0;
        osc_lvl_d = !osc_lvl_q;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      osc_cnt_q  <= '0;
      osc_lvl_q  <= 1'b0;
      clk_prev_q <= 1'b0;
      frm_prev_q <= 1'b0;
    end
    else
    begin
      osc_cnt_q  <= osc_cnt_d;
      osc_lvl_q  <= osc_lvl_d;
      clk_prev_q <= link_sync.clk;
      frm_prev_q <= link_sync.frame;
    end
  end

  // Display tick from oscillator or from external clock edges
  assign osc_rise  = o_osc_enable && !osc_lvl_q && osc_lvl_d;
  assign ext_rise  = run && !strap_q.clk_src_int && link_sync.clk && !clk_prev_q;
  assign tick      = strap_q.clk_src_int ? osc_rise : ext_rise;
  assign frm_edge  = run && !strap_q.master && (link_sync.frame != frm_prev_q);
  assign frame_lvl = master ? frame_q : link_sync.frame;
  assign blank_lvl = master ? blank_q : link_sync.blank_n;

  // Line and frame timing: generated in master, followed in slave
  always_comb
  begin
    line_d   = line_q;
    frame_d  = frame_q;
    blank_d  = master ? ctrl_q.display_on : 1'b0;
    static_d = master && ctrl_q.static_on && frame_q;
    tick_d   = tick;
    if (frm_edge)
    begin
      line_d = '0;
    end
    else if (tick)
    begin
      line_d = line_q + 1'b1;
      if (line_q == dtm_pkg::LINE_W'(LINES - 1))
      begin
        line_d = '0;
        if (master)
        begin
          frame_d = !frame_q;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      line_q   <= '0;
      frame_q  <= 1'b0;
      blank_q  <= 1'b0;
      static_q <= 1'b0;
      tick_q   <= 1'b0;
    end
    else
    begin
      line_q   <= line_d;
      frame_q  <= frame_d;
      blank_q  <= blank_d;
      static_q <= static_d;
      tick_q   <= tick_d;
    end
  end

  // Pin drivers and enables
  assign o_display_clock_pin    = osc_lvl_q;
  assign o_display_clock_pin_oe = master && strap_q.clk_src_int;
  assign o_ac_drive_frame       = frame_q;
  assign o_ac_drive_frame_oe    = master;
  assign o_display_blank_n      = blank_q;
  assign o_display_blank_n_oe   = master;
  assign o_static_drive_out     = static_q;
  assign o_display_tick         = tick_q;
  assign o_frame_level          = frame_lvl;
  assign o_blank_active         = run && !blank_lvl;

  // Checks on the decoded modes and timing, all on the system clock
  default clocking cb_sys @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  property p_osc_ticks;
    o_osc_enable |-> ##[RUN_BOUND_LO:RUN_BOUND_HI] o_display_tick;
  endproperty
  a_osc_ticks: assert property (p_osc_ticks) else $error("no display tick from oscillator");
  property p_osc_frozen;
    !o_osc_enable && !$past(o_osc_enable) |-> $stable(osc_lvl_q);
  endproperty
  a_osc_frozen: assert property (p_osc_frozen) else $error("oscillator moved while off");
  property p_slave_follow;
    frm_edge |=> (line_q == '0) && (o_frame_level == $past(link_sync.frame));
  endproperty
  a_slave_follow: assert property (p_slave_follow) else $error("slave missed frame edge");
  property p_master_frame;
    master && tick && (line_q == dtm_pkg::LINE_W'(LINES - 1)) |=> $changed(o_ac_drive_frame);
  endproperty
  a_master_frame: assert property (p_master_frame) else $error("master frame did not flip");
  property p_pin_dirs;
    (o_ac_drive_frame_oe == master) && (o_display_blank_n_oe == master) &&
    (!o_display_clock_pin_oe || (master && o_osc_enable));
  endproperty
  a_pin_dirs: assert property (p_pin_dirs) else $error("pin direction not from strap");
  property p_blank_out;
    master ##1 master |-> o_display_blank_n == $past(ctrl_q.display_on);
  endproperty
  a_blank_out: assert property (p_blank_out) else $error("blank output not display on");
  property p_static_out;
    o_static_drive_out |-> $past(master) && $past(ctrl_q.static_on);
  endproperty
  a_static_out: assert property (p_static_out) else $error("static drive out of mode");
  property p_slave_analog;
    !master |-> !o_use_internal_resistors && !o_high_power_mode;
  endproperty
  a_slave_analog: assert property (p_slave_analog) else $error("analog strap used in slave");
  property p_master_power;
    master |-> (o_high_power_mode != strap_q.hpm_n) && (o_use_internal_resistors == strap_q.regulator_resistor_select);
  endproperty
  a_master_power: assert property (p_master_power) else $error("analog mode not from strap");
  property p_serial_noread;
    run && !strap_q.parallel_if |-> !o_readback_enable;
  endproperty
  a_serial_noread: assert property (p_serial_noread) else $error("readback in serial mode");

endmodule

// >>> verilog/dtm_sync2.sv
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level or a clock far below i_sys_clk.
*/
module dtm_sync2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule
